// [hw/svd_pkg.sv]
// shared constants and state types of the supply voltage detect controller
package svd_pkg;

   // -----------------------------------------------------------------
   // register map (byte addresses on the avalon slave)
   // -----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;   // voltage_detect_control
   localparam logic [3:0] ADDR_FLAG = 4'h4;   // peripheral_flag_reg_two
   localparam logic [3:0] ADDR_IEN  = 4'h8;   // voltage_event_irq_enable
   localparam logic [3:0] ADDR_CORE = 4'hc;   // core_irq_control_reg

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int CTRL_DIR_BIT    = 7;
   localparam int CTRL_UNUSED_BIT = 6;
   localparam int CTRL_STABLE_BIT = 5;
   localparam int CTRL_EN_BIT     = 4;
   localparam int CTRL_LEVEL_MSB  = 3;
   localparam int FLAG_EVENT_BIT  = 2;
   localparam int IEN_EVENT_BIT   = 2;
   localparam int CORE_GIE_BIT    = 7;

   // -----------------------------------------------------------------
   // reset values and codes
   // -----------------------------------------------------------------
   localparam logic [3:0] LEVEL_RESET = 4'h5;
   localparam logic [3:0] LEVEL_EXT   = 4'hf;

   // -----------------------------------------------------------------
   // settle timing, counted on the clock-independent timebase
   // -----------------------------------------------------------------
   localparam int         TICK_PERIOD_NS = 1000;
   localparam int         SETTLE_TIME_NS = 20000;
   localparam logic [7:0] SETTLE_TICKS   =
      8'((SETTLE_TIME_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS);

   // -----------------------------------------------------------------
   // state types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        tick_q;
      logic [7:0]  cnt;
      logic        done;
   } svd_settle_t;

   typedef struct packed {
      logic        dir;
      logic        stable;
      logic        en;
      logic [3:0]  level;
      logic        flag;
      logic        ien;
      logic        global_irq_enable;
      logic        ext_sel;
      logic        irq;
      logic        wake;
      logic        waitreq;
      logic [31:0] rdata;
   } svd_top_t;

   localparam svd_top_t TOP_RESET = '{level: LEVEL_RESET, waitreq: 1'b1, default: '0};

endpackage

// [hw/svd_sync.sv]
// two-flop synchroniser, also used as the reset release stage
`timescale 1ns/100ps
module svd_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } svd_sync_t;

   svd_sync_t s;
   svd_sync_t next_s;

   // first stage is read only by the second stage
   always_comb begin
      next_s.meta = i_d;
      next_s.q    = s.meta;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_q = s.q;
endmodule

// [hw/svd_settle.sv]
// reference settle timer running from the clock-independent timebase
`timescale 1ns/100ps
module svd_settle (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_en,
   input  wire logic i_tick,
   output logic      o_done
);
   svd_pkg::svd_settle_t s;
   svd_pkg::svd_settle_t next_s;

   // counts timebase edges, so the interval does not follow the core clock
   always_comb begin
      next_s        = s;
      next_s.tick_q = i_tick;
      if (!i_en) begin
         next_s.cnt  = 8'h00;
         next_s.done = 1'b0;
      end else if (i_tick && !s.tick_q && !s.done) begin
         next_s.cnt  = s.cnt + 8'h01;
         next_s.done = (s.cnt + 8'h01) == svd_pkg::SETTLE_TICKS;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_done = s.done;
endmodule

// [hw/svd_ctrl.sv]
// supply voltage detect controller: registers, event logic and analogue controls
`timescale 1ns/100ps
module svd_ctrl (
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RSTN,
   input  wire logic [3:0]  I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   input  wire logic [3:0]  I_AVS_BYTEENABLE,
   output logic      [31:0] O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   input  wire logic        I_CMP_ABOVE,
   input  wire logic        I_CMP_BELOW,
   input  wire logic        I_REF_READY,
   input  wire logic        I_TIMEBASE_TICK,
   input  wire logic        I_SLEEP,
   output logic             O_DET_PWR_EN,
   output logic      [3:0]  O_TRIP_LEVEL,
   output logic             O_EXT_SEL,
   output logic             O_TRIP_DIR,
   output logic             O_IRQ,
   output logic             O_WAKE
);

   // -----------------------------------------------------------------
   // reset release and input synchronisers
   // -----------------------------------------------------------------
   logic       rst_n;
   logic [3:0] async_q;
   logic       settle_done;
   logic       above;
   logic       below;
   logic       ref_ok;

   // reset is asserted at once but released through two flops
   svd_sync #(.W(1)) u_rst_sync (
      .i_clk   (I_CORE_CLK),
      .i_rst_n (I_RSTN),
      .i_d     (1'b1),
      .o_q     (rst_n)
   );

   // comparator, reference ready and timebase come from the analogue side
   svd_sync #(.W(4)) u_in_sync (
      .i_clk   (I_CORE_CLK),
      .i_rst_n (rst_n),
      .i_d     ({I_TIMEBASE_TICK, I_REF_READY, I_CMP_BELOW, I_CMP_ABOVE}),
      .o_q     (async_q)
   );

   assign above  = async_q[0];
   assign below  = async_q[1];
   assign ref_ok = async_q[2];

   svd_pkg::svd_top_t s;
   svd_pkg::svd_top_t next_s;

   svd_settle u_settle (
      .i_clk   (I_CORE_CLK),
      .i_rst_n (rst_n),
      .i_en    (s.en),
      .i_tick  (async_q[3]),
      .o_done  (settle_done)
   );

   // -----------------------------------------------------------------
   // register read decode
   // -----------------------------------------------------------------
   function automatic logic [31:0] read_reg(input logic [3:0] addr, input svd_pkg::svd_top_t st);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (addr)
         svd_pkg::ADDR_CTRL: begin
            d[svd_pkg::CTRL_DIR_BIT]    = st.dir;
            d[svd_pkg::CTRL_UNUSED_BIT] = 1'b0;
            d[svd_pkg::CTRL_STABLE_BIT] = st.stable;
            d[svd_pkg::CTRL_EN_BIT]     = st.en;
            d[svd_pkg::CTRL_LEVEL_MSB:0] = st.level;
         end
         svd_pkg::ADDR_FLAG: d[svd_pkg::FLAG_EVENT_BIT] = st.flag;
         svd_pkg::ADDR_IEN:  d[svd_pkg::IEN_EVENT_BIT]  = st.ien;
         svd_pkg::ADDR_CORE: d[svd_pkg::CORE_GIE_BIT]   = st.global_irq_enable;
         default:            d = 32'h0000_0000;           // unmapped reads as zero
      endcase
      return d;
   endfunction

   // a write that lands this cycle at the given register
   function automatic logic wr_hit(input logic       wr_ok,
                                   input logic [3:0] addr,
                                   input logic [3:0] reg_addr);
      return wr_ok && (addr == reg_addr);
   endfunction

   // -----------------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------------
   logic       req;
   logic       wr;
   logic [7:0] wd;
   logic       cond;
   logic       set_evt;

   // one wait cycle per access, then a single answer cycle
   always_comb begin
      next_s  = s;
      req     = I_AVS_READ || I_AVS_WRITE;
      wr      = I_AVS_WRITE && !s.waitreq && I_AVS_BYTEENABLE[0];
      wd      = I_AVS_WRITEDATA[7:0];
      cond    = s.dir ? above : below;
      set_evt = s.en && s.stable && cond;

      next_s.waitreq = !(req && s.waitreq);
      if (I_AVS_READ && s.waitreq) begin
         next_s.rdata = read_reg(I_AVS_ADDRESS, s);
      end

      // bits 6 and 5 of the control word are dropped on write
      if (wr_hit(wr, I_AVS_ADDRESS, svd_pkg::ADDR_CTRL)) begin
         next_s.dir   = wd[svd_pkg::CTRL_DIR_BIT];
         next_s.en    = wd[svd_pkg::CTRL_EN_BIT];
         next_s.level = wd[svd_pkg::CTRL_LEVEL_MSB:0];
      end
      if (wr_hit(wr, I_AVS_ADDRESS, svd_pkg::ADDR_IEN)) begin
         next_s.ien = wd[svd_pkg::IEN_EVENT_BIT];
      end
      if (wr_hit(wr, I_AVS_ADDRESS, svd_pkg::ADDR_CORE)) begin
         next_s.global_irq_enable = wd[svd_pkg::CORE_GIE_BIT];
      end

      // an excursion in the clearing cycle wins over the clear
      if (wr_hit(wr, I_AVS_ADDRESS, svd_pkg::ADDR_FLAG)) begin
         next_s.flag = wd[svd_pkg::FLAG_EVENT_BIT] || set_evt;
      end else begin
         next_s.flag = s.flag || set_evt;
      end

      // disabling drops the stable flag at once; enabling waits for the timer
      next_s.stable  = next_s.en && s.en && settle_done && ref_ok;
      next_s.ext_sel = next_s.en && (next_s.level == svd_pkg::LEVEL_EXT);
      next_s.irq     = next_s.flag && next_s.ien && next_s.global_irq_enable;
      // wake needs no global enable; vectoring stays with the core
      next_s.wake    = I_SLEEP && next_s.flag;
   end

   // all state except the settle timer and synchronisers sits in one register so its reset values come from one place
   always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s <= svd_pkg::TOP_RESET;
      end else begin
         s <= next_s;
      end
   end

   // -----------------------------------------------------------------
   // outputs, each straight from the state register
   // -----------------------------------------------------------------
   assign O_AVS_READDATA    = s.rdata;
   assign O_AVS_WAITREQUEST = s.waitreq;
   assign O_DET_PWR_EN      = s.en;
   assign O_TRIP_LEVEL      = s.level;
   assign O_EXT_SEL         = s.ext_sel;
   assign O_TRIP_DIR        = s.dir;
   assign O_IRQ             = s.irq;
   assign O_WAKE            = s.wake;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!rst_n);

   // decoded views of the landing write, so properties can look one cycle back
   logic       flag_hit;
   logic       flag_wr;
   logic       flag_clr;
   logic       ctrl_wr;
   logic [3:0] wr_level;
   logic       wr_en;
   logic       wr_dir;
   assign flag_hit = wr_hit(wr, I_AVS_ADDRESS, svd_pkg::ADDR_FLAG);
   assign flag_wr  = flag_hit && wd[svd_pkg::FLAG_EVENT_BIT];
   assign flag_clr = flag_hit && !wd[svd_pkg::FLAG_EVENT_BIT];
   assign ctrl_wr  = wr_hit(wr, I_AVS_ADDRESS, svd_pkg::ADDR_CTRL);
   assign wr_level = wd[svd_pkg::CTRL_LEVEL_MSB:0];
   assign wr_en    = wd[svd_pkg::CTRL_EN_BIT];
   assign wr_dir   = wd[svd_pkg::CTRL_DIR_BIT];

   unused_bit_a: assert property (
      (I_AVS_READ && s.waitreq && I_AVS_ADDRESS == svd_pkg::ADDR_CTRL)
      |=> !O_AVS_WAITREQUEST && !O_AVS_READDATA[svd_pkg::CTRL_UNUSED_BIT])
      else $error("control bit 6 read as one");

   stable_ro_a: assert property (
      (!s.stable && !settle_done) |=> !s.stable)
      else $error("stable flag set before the settle timer expired");

   unstable_quiet_a: assert property (
      (!s.stable && !s.flag && !flag_wr) |=> !s.flag)
      else $error("event flag set while reference unstable");

   enable_settle_a: assert property (
      $rose(s.en) |-> !s.stable ##1 !s.stable)
      else $error("stable flag not held clear after enable");

   ext_route_a: assert property (
      (next_s.en && next_s.level == svd_pkg::LEVEL_EXT) |=> O_EXT_SEL)
      else $error("external trip input not selected for code 1111");

   high_event_a: assert property (
      (s.en && s.stable && s.dir && above) |=> s.flag)
      else $error("rising excursion did not set the flag");

   low_event_a: assert property (
      (s.en && s.stable && !s.dir && below) |=> s.flag)
      else $error("falling excursion did not set the flag");

   irq_gate_a: assert property (
      O_IRQ |-> (s.flag && s.ien && s.global_irq_enable))
      else $error("interrupt without flag and both enables");

   off_quiet_a: assert property (
      (!s.en && !s.flag && !flag_wr) |=> !s.flag)
      else $error("disabled detector produced an event");

   sleep_wake_a: assert property (
      (I_SLEEP && next_s.flag) |=> O_WAKE)
      else $error("event in sleep did not raise wake");

   bus_answer_a: assert property (
      ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST) |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
      else $error("bus answer not exactly one cycle after request");

   level_write_a: assert property (
      ctrl_wr |=> O_TRIP_LEVEL == $past(wr_level))
      else $error("trip level pins do not follow the control write");

   power_write_a: assert property (
      ctrl_wr |=> O_DET_PWR_EN == $past(wr_en))
      else $error("power enable pin does not follow the control write");

   dir_write_a: assert property (
      ctrl_wr |=> O_TRIP_DIR == $past(wr_dir))
      else $error("direction pin does not follow the control write");

   disable_drop_a: assert property (
      (ctrl_wr && !wr_en) |=> !s.stable)
      else $error("stable flag survived a disable");

   settle_wait_a: assert property (
      $rose(s.en) |=> !s.stable [*8])
      else $error("stable flag set without a settle interval");

   ref_gate_a: assert property (
      $rose(s.stable) |-> $past(ref_ok) && $past(settle_done))
      else $error("stable flag set before reference and timer were ready");

   flag_sticky_a: assert property (
      (s.flag && !flag_clr) |=> s.flag)
      else $error("event flag dropped without a software clear");

   flag_clear_a: assert property (
      (flag_clr && !set_evt) |=> !s.flag)
      else $error("software clear of the event flag had no effect");

   flag_reset_a: assert property (
      (flag_clr && set_evt) |=> s.flag)
      else $error("event flag not set again while the condition holds");

   irq_raise_a: assert property (
      (s.flag && s.ien && s.global_irq_enable && !wr) |=> O_IRQ)
      else $error("enabled event flag did not raise the interrupt");

   wake_off_a: assert property (
      !I_SLEEP |=> !O_WAKE)
      else $error("wake raised while the device was awake");

   ext_clear_a: assert property (
      !(next_s.en && next_s.level == svd_pkg::LEVEL_EXT) |=> !O_EXT_SEL)
      else $error("external trip input routed without code 1111");

   bus_upper_a: assert property (
      !O_AVS_WAITREQUEST |-> O_AVS_READDATA[31:8] == 24'h00_0000)
      else $error("read data carries bits above the low byte");

   settle_cover_c: cover property ($rose(s.stable));
   event_cover_c:  cover property ($rose(s.flag));
   irq_cover_c:    cover property ($rose(O_IRQ));
   ext_cover_c:    cover property (O_EXT_SEL && s.stable && s.flag);
   wake_cover_c:   cover property ($rose(O_WAKE));

endmodule

// [verif/svd_afe_model.sv]
// behavioural model of the analogue comparator, reference and timebase
`timescale 1ns/100ps
module svd_afe_model (
   input  wire logic        i_pwr_en,
   input  wire logic [3:0]  i_level,
   input  wire logic        i_ext_sel,
   input  wire logic [15:0] i_supply_mv,
   input  wire logic [15:0] i_ext_mv,
   output logic             o_above,
   output logic             o_below,
   output logic             o_ref_ready,
   output logic             o_tick
);
   int trip_mv;
   int mon_mv;

   // ----------------------------------------------------------------
   // comparator: unpowered means no output at all
   // ----------------------------------------------------------------
   always_comb begin
      trip_mv = i_ext_sel ? 1200 : 1000 + 200 * int'(i_level);
      mon_mv  = i_ext_sel ? int'(i_ext_mv) : int'(i_supply_mv);
      o_above = i_pwr_en && (mon_mv >= trip_mv);
      o_below = i_pwr_en && (mon_mv <= trip_mv);
   end

   // reference needs a while after power-up; drops at once on power-down
   always @(i_pwr_en) begin
      o_ref_ready = 1'b0;
      if (i_pwr_en) begin
         #3000 o_ref_ready = i_pwr_en;
      end
   end

   // free-running timebase, phase unrelated to the core clock
   initial begin
      o_tick = 1'b0;
      #37;
      forever #500 o_tick = ~o_tick;
   end
endmodule

// [verif/testbench.sv]
// self-checking testbench of the supply voltage detect controller
`timescale 1ns/100ps
module testbench;
   logic        clk;
   logic        rstn;
   logic [3:0]  addr;
   logic        rd;
   logic        wr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        wreq;
   logic        above, below, ref_rdy, tick, sleep;
   logic        pwr_en, ext_sel, dir, irq, wake;
   logic [3:0]  level;
   logic [15:0] supply_mv;
   logic [15:0] ext_mv;
   logic [7:0]  q;
   int          failures;
   int          n_tests;
   int          i;

   // ----------------------------------------------------------------
   // design and far-side model
   // ----------------------------------------------------------------
   svd_ctrl u_dut (
      .I_CORE_CLK(clk), .I_RSTN(rstn), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
      .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'h1),
      .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq), .I_CMP_ABOVE(above),
      .I_CMP_BELOW(below), .I_REF_READY(ref_rdy), .I_TIMEBASE_TICK(tick),
      .I_SLEEP(sleep), .O_DET_PWR_EN(pwr_en), .O_TRIP_LEVEL(level),
      .O_EXT_SEL(ext_sel), .O_TRIP_DIR(dir), .O_IRQ(irq), .O_WAKE(wake));

   svd_afe_model u_afe (
      .i_pwr_en(pwr_en), .i_level(level), .i_ext_sel(ext_sel),
      .i_supply_mv(supply_mv), .i_ext_mv(ext_mv), .o_above(above),
      .o_below(below), .o_ref_ready(ref_rdy), .o_tick(tick));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // verdict, compare and bus tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("compares %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // request held until waitrequest is sampled low, bounded wait
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      rd    <= ~w;
      wr    <= w;
      addr  <= a;
      wdata <= {24'h0, d};
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (wreq === 1'b0) break;
      end
      if (n == 20) begin
         failures++;
         final_report();
      end
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   // polls the stable flag; the settle interval is counted in ticks
   task automatic wait_stable();
      int n;
      for (n = 0; n < 200; n++) begin
         bus(1'b0, 4'h0, 8'h00);
         if (q[5] === 1'b1) break;
      end
      if (n == 200) begin
         failures++;
         final_report();
      end
      repeat (4) @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      failures = 0;
      n_tests = 0;
      rstn = 1'b0;
      addr = 4'h0;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      sleep = 1'b0;
      supply_mv = 16'd3300;
      ext_mv = 16'd2000;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);

      // reset state and an unmapped hole
      bus(1'b0, 4'h0, 8'h00);
      chk("ctrl reset", q, 8'h05);
      chk("level pins", {4'h0, level}, 8'h05);
      chk("power off", {7'h0, pwr_en}, 8'h00);
      bus(1'b0, 4'h2, 8'h00);
      chk("unmapped", q, 8'h00);
      $display("test reset done");

      // all ones: bits 6 and 5 stay clear, external input routed
      bus(1'b1, 4'h0, 8'hff);
      bus(1'b0, 4'h0, 8'h00);
      chk("ctrl ones", q, 8'h9f);
      chk("ext sel", {7'h0, ext_sel}, 8'h01);
      chk("dir pin", {7'h0, dir}, 8'h01);
      chk("power on", {7'h0, pwr_en}, 8'h01);
      bus(1'b0, 4'h4, 8'h00);
      chk("flag unsettled", q, 8'h00);
      wait_stable();
      bus(1'b0, 4'h4, 8'h00);
      chk("flag ext above", q, 8'h04);
      $display("test external done");

      // setup order, falling supply on the highest internal level
      bus(1'b1, 4'h0, 8'h0e);
      bus(1'b0, 4'h0, 8'h00);
      chk("disable stable", q, 8'h0e);
      chk("ext off", {7'h0, ext_sel}, 8'h00);
      bus(1'b1, 4'h0, 8'h1e);
      bus(1'b1, 4'h4, 8'h00);
      bus(1'b0, 4'h4, 8'h00);
      chk("flag early", q, 8'h00);
      bus(1'b0, 4'h0, 8'h00);
      chk("restart", q, 8'h1e);
      wait_stable();
      bus(1'b0, 4'h4, 8'h00);
      chk("flag below", q, 8'h04);
      bus(1'b1, 4'h4, 8'h00);
      bus(1'b0, 4'h4, 8'h00);
      chk("flag persists", q, 8'h04);
      bus(1'b1, 4'h8, 8'h04);
      repeat (2) @(posedge clk);
      chk("irq no gie", {7'h0, irq}, 8'h00);
      bus(1'b1, 4'hc, 8'h80);
      repeat (2) @(posedge clk);
      chk("irq on", {7'h0, irq}, 8'h01);
      sleep <= 1'b1;
      repeat (2) @(posedge clk);
      chk("wake", {7'h0, wake}, 8'h01);
      sleep <= 1'b0;
      repeat (2) @(posedge clk);
      chk("wake off", {7'h0, wake}, 8'h00);
      $display("test low supply done");

      // disabled detector stays quiet; ctrl cannot set stable
      bus(1'b1, 4'h0, 8'h2e);
      bus(1'b1, 4'h4, 8'h00);
      repeat (10) @(posedge clk);
      bus(1'b0, 4'h4, 8'h00);
      chk("flag off", q, 8'h00);
      bus(1'b0, 4'h0, 8'h00);
      chk("stable ro", q, 8'h0e);
      chk("irq off", {7'h0, irq}, 8'h00);
      chk("power down", {7'h0, pwr_en}, 8'h00);
      $display("test disabled done");

      // level codes 1 to 14 reach the trip pins
      for (i = 1; i < 15; i++) begin
         bus(1'b1, 4'h0, 8'(i));
         repeat (2) @(posedge clk);
         chk("level", {4'h0, level}, 8'(i));
      end
      $display("test levels done");
      final_report();
   end
endmodule
